// ==== common/adc_ctrl_pkg.sv ====
// Register map, field positions and reset values of the converter control register bank.
package adc_ctrl_pkg;

  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_DATA_CH = 4;
  localparam int unsigned NUM_CLK_CH = 2;

  localparam logic [12:0] ADDR_CHANNEL_INDEX = 13'h005;
  localparam logic [12:0] ADDR_POWER_MODE    = 13'h008;
  localparam logic [12:0] ADDR_OFFSET_CHOP   = 13'h00C;
  localparam logic [12:0] ADDR_SER_FORMAT    = 13'h021;
  localparam logic [12:0] ADDR_CH_PWR_RST    = 13'h022;
  localparam logic [12:0] ADDR_TRANSFER      = 13'h0FF;
  localparam logic [12:0] ADDR_DOWNGRADE     = 13'h100;
  localparam logic [12:0] ADDR_IO_PULLDOWN   = 13'h101;
  localparam logic [12:0] ADDR_CM_POWER      = 13'h102;
  localparam logic [12:0] ADDR_SYNC          = 13'h109;

  localparam logic [7:0] RST_CHANNEL_INDEX = 8'h3F;
  localparam logic [7:0] RST_POWER_MODE    = 8'h00;
  localparam logic [7:0] RST_OFFSET_CHOP   = 8'h00;
  localparam logic [7:0] RST_SER_FORMAT    = 8'h30;
  localparam logic [1:0] RST_CH_PWR_RST    = 2'h0;
  localparam logic [7:0] RST_DOWNGRADE     = 8'h00;
  localparam logic [7:0] RST_IO_PULLDOWN   = 8'h00;
  localparam logic [7:0] RST_CM_POWER      = 8'h00;
  localparam logic [7:0] RST_SYNC          = 8'h00;

  localparam int unsigned IDX_DATA_LSB  = 0;
  localparam int unsigned IDX_CLK_LSB   = 4;
  localparam int unsigned PM_PIN_FUNC   = 5;
  localparam int unsigned PM_MODE_LSB   = 0;
  localparam int unsigned CHOP_BIT      = 2;
  localparam int unsigned CH_PD_BIT     = 0;
  localparam int unsigned CH_ORST_BIT   = 1;
  localparam int unsigned SF_LSB_FIRST  = 7;
  localparam int unsigned SF_LANE_LSB   = 4;
  localparam int unsigned SF_PLL_LOW    = 3;
  localparam int unsigned SF_DBL_FRAME  = 2;
  localparam int unsigned SF_WSIZE_LSB  = 0;
  localparam int unsigned DG_EN_BIT     = 6;
  localparam int unsigned DG_RES_LSB    = 4;
  localparam int unsigned DG_RATE_LSB   = 0;
  localparam int unsigned XFER_BIT      = 0;
  localparam int unsigned PULLDOWN_BIT  = 0;
  localparam int unsigned CM_PD_BIT     = 3;
  localparam int unsigned SYNC_EN_BIT   = 0;
  localparam int unsigned SYNC_NEXT_BIT = 1;

  localparam logic [7:0] MASK_POWER_MODE = 8'h23;
  localparam logic [7:0] MASK_OFFSET_CHOP = 8'h04;
  localparam logic [7:0] MASK_DOWNGRADE  = 8'h77;
  localparam logic [7:0] MASK_IO_PULLDOWN = 8'h01;
  localparam logic [7:0] MASK_CM_POWER   = 8'h08;
  localparam logic [7:0] MASK_SYNC       = 8'h03;

  localparam logic [1:0] PD_NORMAL    = 2'h0;
  localparam logic [1:0] PD_FULL      = 2'h1;
  localparam logic [1:0] PD_STANDBY   = 2'h2;
  localparam logic [1:0] PD_DIG_RESET = 2'h3;

  typedef enum logic [3:0] {
    PWR_NORMAL    = 4'b0001,
    PWR_FULL_PD   = 4'b0010,
    PWR_STANDBY   = 4'b0100,
    PWR_DIG_RESET = 4'b1000
  } power_state_t;

endpackage

// ==== src/adc_control_register_bank.sv ====
// Control register bank of the four-channel converter, written and read over the serial control port.
`timescale 1ns/1ps

// Operation
// - Channel index bits 3..0 pick which data channels per-channel writes touch.
// - Channel index also picks output clock channels for their smaller per-channel set.
// - All registers except the downgrade register act as soon as written.
// - Writing transfer bit 0 as one copies pending downgrade settings to active.
// - Power-down pin gives standby when power-mode bit 5 set, else full power-down.
// - Internal power-down field 00 keeps datapath clocks and outputs on, with no datapath reset.
// - Field 01 stops datapath clocks, resets datapath and disables outputs.
// - Field 10 stops datapath clocks and disables outputs, no datapath reset.
// - Field 11 resets datapath and disables outputs with clocks running, never the serial port.
// - Serial control port works in every mode; only power-on reset clears it.
// - Offset chop control bit 2 enables first-stage chopping.
// - Per-channel register: bit 0 power-down, bit 1 output reset, reset 00.
// - Downgrade limits rate capability and resolution, never the actual sample rate.
// - Pull-down control bit 0 set disables the serial data pin pull-down.
// - Common-mode control bit 3 set powers down the common-mode generator.
module adc_control_register_bank
  import adc_ctrl_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_clk_en,
  input  wire logic              i_wr_en,
  input  wire logic              i_rd_en,
  input  wire logic [12:0]       i_addr,
  input  wire logic [7:0]        i_wr_data,
  input  wire logic              i_external_powerdown_pin,
  input  wire logic              i_sync_event,
  output logic      [7:0]        o_rd_data,
  output logic                   o_rd_valid,
  output logic                   o_datapath_clk_en,
  output logic                   o_datapath_reset,
  output logic                   o_output_en,
  output logic                   o_chop_en,
  output logic      [3:0]        o_chan_powerdown,
  output logic      [3:0]        o_chan_output_reset,
  output logic      [1:0]        o_clkch_powerdown,
  output logic      [1:0]        o_clkch_output_reset,
  output logic                   o_ser_lsb_first,
  output logic      [2:0]        o_ser_lane_mode,
  output logic                   o_ser_pll_low_rate,
  output logic                   o_ser_double_frame,
  output logic      [1:0]        o_serial_word_size,
  output logic                   o_override_en,
  output logic      [1:0]        o_resolution_code,
  output logic      [2:0]        o_max_rate_code,
  output logic                   o_sdio_pulldown_dis,
  output logic                   o_common_mode_voltage_pd,
  output logic                   o_sync_en,
  output logic                   o_sync_pulse
);

  logic [7:0]         chan_index_reg;
  logic [7:0]         power_mode_reg;
  logic [7:0]         chop_reg;
  logic [7:0]         ser_format_reg;
  logic [1:0]         data_ch_reg [NUM_DATA_CH];
  logic [1:0]         clk_ch_reg  [NUM_CLK_CH];
  logic [7:0]         downgrade_pending_reg;
  logic [7:0]         downgrade_active_reg;
  logic [7:0]         pulldown_reg;
  logic [7:0]         cm_power_reg;
  logic [7:0]         sync_reg;
  logic               sync_used_reg;
  power_state_t       power_state_reg;
  power_state_t       power_state_next;

  logic               wr_hit_index;
  logic               wr_hit_ch;
  logic               wr_hit_xfer;
  logic [3:0]         data_sel;
  logic [1:0]         clk_sel;
  logic [7:0]         rd_mux;

  // Hit on a given address only while the port writes.
  function automatic logic wr_hit(input logic en, input logic [12:0] a, input logic [12:0] ref_a);
    wr_hit = en && (a == ref_a);
  endfunction

  // Value read back from the per-channel register is that of the lowest selected channel.
  function automatic logic [1:0] first_selected(input logic [3:0] dsel, input logic [1:0] csel,
                                                input logic [1:0] d0, input logic [1:0] d1,
                                                input logic [1:0] d2, input logic [1:0] d3,
                                                input logic [1:0] c0, input logic [1:0] c1);
    logic [1:0] v;
    v = 2'h0;
    if (dsel[0]) v = d0;
    else if (dsel[1]) v = d1;
    else if (dsel[2]) v = d2;
    else if (dsel[3]) v = d3;
    else if (csel[0]) v = c0;
    else if (csel[1]) v = c1;
    first_selected = v;
  endfunction

  assign data_sel     = chan_index_reg[IDX_DATA_LSB +: NUM_DATA_CH];
  assign clk_sel      = chan_index_reg[IDX_CLK_LSB +: NUM_CLK_CH];
  assign wr_hit_index = wr_hit(i_wr_en, i_addr, ADDR_CHANNEL_INDEX);
  assign wr_hit_ch    = wr_hit(i_wr_en, i_addr, ADDR_CH_PWR_RST);
  assign wr_hit_xfer  = wr_hit(i_wr_en, i_addr, ADDR_TRANSFER);

  // Only the power-on reset clears the register file; no power mode touches it. 
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      chan_index_reg <= RST_CHANNEL_INDEX;
      power_mode_reg <= RST_POWER_MODE;
      chop_reg       <= RST_OFFSET_CHOP;
      ser_format_reg <= RST_SER_FORMAT;
      pulldown_reg   <= RST_IO_PULLDOWN;
      cm_power_reg   <= RST_CM_POWER;
      sync_reg       <= RST_SYNC;
    end else if (i_clk_en) begin
      if (wr_hit_index) begin
        chan_index_reg <= i_wr_data;
      end
      if (wr_hit(i_wr_en, i_addr, ADDR_POWER_MODE)) begin
        power_mode_reg <= i_wr_data & MASK_POWER_MODE;
      end
      if (wr_hit(i_wr_en, i_addr, ADDR_OFFSET_CHOP)) begin
        chop_reg <= i_wr_data & MASK_OFFSET_CHOP;
      end
      if (wr_hit(i_wr_en, i_addr, ADDR_SER_FORMAT)) begin
        ser_format_reg <= i_wr_data;
      end
      if (wr_hit(i_wr_en, i_addr, ADDR_IO_PULLDOWN)) begin
        pulldown_reg <= i_wr_data & MASK_IO_PULLDOWN;
      end
      if (wr_hit(i_wr_en, i_addr, ADDR_CM_POWER)) begin
        cm_power_reg <= i_wr_data & MASK_CM_POWER;
      end
      if (wr_hit(i_wr_en, i_addr, ADDR_SYNC)) begin
        sync_reg <= i_wr_data & MASK_SYNC;
      end
    end
  end

  // Per-channel power-down and output reset, written only into the selected channels.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_DATA_CH; i++) data_ch_reg[i] <= RST_CH_PWR_RST;
      for (int j = 0; j < NUM_CLK_CH; j++) clk_ch_reg[j] <= RST_CH_PWR_RST;
    end else if (i_clk_en && wr_hit_ch) begin
      for (int i = 0; i < NUM_DATA_CH; i++) begin
        if (data_sel[i]) data_ch_reg[i] <= i_wr_data[CH_ORST_BIT:CH_PD_BIT];
      end
      for (int j = 0; j < NUM_CLK_CH; j++) begin
        if (clk_sel[j]) clk_ch_reg[j] <= i_wr_data[CH_ORST_BIT:CH_PD_BIT];
      end
    end
  end

  // Downgrade settings wait in a shadow until the transfer bit is written.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      downgrade_pending_reg <= RST_DOWNGRADE;
      downgrade_active_reg  <= RST_DOWNGRADE;
    end else if (i_clk_en) begin
      if (wr_hit(i_wr_en, i_addr, ADDR_DOWNGRADE)) begin
        downgrade_pending_reg <= i_wr_data & MASK_DOWNGRADE;
      end
      if (wr_hit_xfer && i_wr_data[XFER_BIT]) begin
        downgrade_active_reg <= downgrade_pending_reg;
      end
    end
  end

  // The pin outranks the internal field, since it is the board's emergency power control.
  always_comb begin
    power_state_next = PWR_NORMAL;
    if (i_external_powerdown_pin) begin
      power_state_next = power_mode_reg[PM_PIN_FUNC] ? PWR_STANDBY : PWR_FULL_PD;
    end else begin
      unique case (power_mode_reg[PM_MODE_LSB +: 2])
        PD_NORMAL:    power_state_next = PWR_NORMAL;
        PD_FULL:      power_state_next = PWR_FULL_PD;
        PD_STANDBY:   power_state_next = PWR_STANDBY;
        PD_DIG_RESET: power_state_next = PWR_DIG_RESET;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      power_state_reg   <= PWR_NORMAL;
      o_datapath_clk_en <= 1'b1;
      o_datapath_reset  <= 1'b0;
      o_output_en       <= 1'b1;
    end else if (i_clk_en) begin
      power_state_reg <= power_state_next;
      unique case (power_state_next)
        PWR_NORMAL: begin
          o_datapath_clk_en <= 1'b1;
          o_datapath_reset  <= 1'b0;
          o_output_en       <= 1'b1;
        end
        PWR_FULL_PD: begin
          o_datapath_clk_en <= 1'b0;
          o_datapath_reset  <= 1'b1;
          o_output_en       <= 1'b0;
        end
        PWR_STANDBY: begin
          o_datapath_clk_en <= 1'b0;
          o_datapath_reset  <= 1'b0;
          o_output_en       <= 1'b0;
        end
        PWR_DIG_RESET: begin
          o_datapath_clk_en <= 1'b1;
          o_datapath_reset  <= 1'b1;
          o_output_en       <= 1'b0;
        end
      endcase
    end
  end

  // Control outputs follow their registers one edge after the write.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_chop_en                <= 1'b0;
      o_chan_powerdown         <= '0;
      o_chan_output_reset      <= '0;
      o_clkch_powerdown        <= '0;
      o_clkch_output_reset     <= '0;
      o_ser_lsb_first          <= 1'b0;
      o_ser_lane_mode          <= 3'h0;
      o_ser_pll_low_rate       <= 1'b0;
      o_ser_double_frame       <= 1'b0;
      o_serial_word_size       <= 2'h0;
      o_override_en            <= 1'b0;
      o_resolution_code        <= 2'h0;
      o_max_rate_code          <= 3'h0;
      o_sdio_pulldown_dis      <= 1'b0;
      o_common_mode_voltage_pd <= 1'b0;
      o_sync_en                <= 1'b0;
    end else if (i_clk_en) begin
      o_chop_en <= chop_reg[CHOP_BIT];
      for (int i = 0; i < NUM_DATA_CH; i++) begin
        o_chan_powerdown[i]    <= data_ch_reg[i][CH_PD_BIT];
        o_chan_output_reset[i] <= data_ch_reg[i][CH_ORST_BIT];
      end
      for (int j = 0; j < NUM_CLK_CH; j++) begin
        o_clkch_powerdown[j]    <= clk_ch_reg[j][CH_PD_BIT];
        o_clkch_output_reset[j] <= clk_ch_reg[j][CH_ORST_BIT];
      end
      o_ser_lsb_first    <= ser_format_reg[SF_LSB_FIRST];
      o_ser_lane_mode    <= ser_format_reg[SF_LANE_LSB +: 3];
      o_ser_pll_low_rate <= ser_format_reg[SF_PLL_LOW];
      o_ser_double_frame <= ser_format_reg[SF_DBL_FRAME];
      o_serial_word_size <= ser_format_reg[SF_WSIZE_LSB +: 2];
      // Only capability limits leave here; the sample clock itself is untouched.
      o_override_en     <= downgrade_active_reg[DG_EN_BIT];
      o_resolution_code <= downgrade_active_reg[DG_RES_LSB +: 2];
      o_max_rate_code   <= downgrade_active_reg[DG_RATE_LSB +: 3];
      o_sdio_pulldown_dis      <= pulldown_reg[PULLDOWN_BIT];
      o_common_mode_voltage_pd <= cm_power_reg[CM_PD_BIT];
      o_sync_en                <= sync_reg[SYNC_EN_BIT];
    end
  end

  // One-shot sync: with sync bit 1 set, after one honoured event further events are dropped until sync is rewritten.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_used_reg <= 1'b0;
      o_sync_pulse  <= 1'b0;
    end else if (i_clk_en) begin
      o_sync_pulse <= 1'b0;
      if (wr_hit(i_wr_en, i_addr, ADDR_SYNC)) begin
        sync_used_reg <= 1'b0;
      end else if (i_sync_event && sync_reg[SYNC_EN_BIT] && !sync_used_reg) begin
        o_sync_pulse  <= 1'b1;
        sync_used_reg <= sync_reg[SYNC_NEXT_BIT];
      end
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (i_addr)
      ADDR_CHANNEL_INDEX: rd_mux = chan_index_reg;
      ADDR_POWER_MODE:    rd_mux = power_mode_reg;
      ADDR_OFFSET_CHOP:   rd_mux = chop_reg;
      ADDR_SER_FORMAT:    rd_mux = ser_format_reg;
      ADDR_CH_PWR_RST:    rd_mux = {6'h00, first_selected(data_sel, clk_sel, data_ch_reg[0], data_ch_reg[1],
                                    data_ch_reg[2], data_ch_reg[3], clk_ch_reg[0], clk_ch_reg[1])};
      ADDR_DOWNGRADE:     rd_mux = downgrade_pending_reg;
      ADDR_IO_PULLDOWN:   rd_mux = pulldown_reg;
      ADDR_CM_POWER:      rd_mux = cm_power_reg;
      ADDR_SYNC:          rd_mux = sync_reg;
      default:            rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rd_data  <= 8'h00;
      o_rd_valid <= 1'b0;
    end else if (i_clk_en) begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_xfer_write;
    i_clk_en && wr_hit_xfer && i_wr_data[XFER_BIT];
  endsequence

  sequence s_mode_held(logic [1:0] m);
    i_clk_en && !i_external_powerdown_pin && power_mode_reg[PM_MODE_LSB +: 2] == m;
  endsequence

  chk_downgrade_waits: assert property (
    (i_clk_en && !wr_hit_xfer) |=> $stable(downgrade_active_reg))
    else $error("Downgrade settings changed without a transfer write.");

  chk_transfer_copies: assert property (
    s_xfer_write ##1 i_clk_en [*2] |-> o_max_rate_code == $past(downgrade_pending_reg[DG_RATE_LSB +: 3], 2))
    else $error("Transfer write did not apply the pending downgrade settings.");

  chk_pin_standby: assert property (
    (i_clk_en && i_external_powerdown_pin && power_mode_reg[PM_PIN_FUNC]) |=>
      (!o_datapath_clk_en && !o_datapath_reset && !o_output_en))
    else $error("Pin with pin function set did not give standby.");

  chk_pin_full_pd: assert property (
    (i_clk_en && i_external_powerdown_pin && !power_mode_reg[PM_PIN_FUNC]) |=> o_datapath_reset)
    else $error("Pin with pin function clear did not give full power-down.");

  chk_normal_mode: assert property (
    s_mode_held(PD_NORMAL) |=> (o_datapath_clk_en && o_output_en && !o_datapath_reset))
    else $error("Normal mode did not keep the datapath running.");

  chk_full_pd_mode: assert property (
    s_mode_held(PD_FULL) |=> (!o_datapath_clk_en && o_datapath_reset && !o_output_en))
    else $error("Full power-down mode outputs wrong.");

  chk_standby_mode: assert property (
    s_mode_held(PD_STANDBY) |=> (!o_datapath_clk_en && !o_datapath_reset && !o_output_en))
    else $error("Standby mode outputs wrong.");

  chk_dig_reset_mode: assert property (
    s_mode_held(PD_DIG_RESET) |=> (o_datapath_reset && power_state_reg == PWR_DIG_RESET))
    else $error("Digital reset mode did not reset the datapath.");

  chk_port_alive: assert property (
    (i_clk_en && i_rd_en && i_addr == ADDR_SYNC) |=> (o_rd_valid && o_rd_data == $past(sync_reg)))
    else $error("Serial port read failed.");

  chk_chop_follow: assert property (
    (i_clk_en && wr_hit(i_wr_en, i_addr, ADDR_OFFSET_CHOP)) ##1 i_clk_en |=>
      o_chop_en == $past(i_wr_data[CHOP_BIT], 2))
    else $error("Chop enable did not follow its control bit.");

  chk_sync_one_shot: assert property (
    (o_sync_pulse && sync_reg[SYNC_NEXT_BIT] && !wr_hit(i_wr_en, i_addr, ADDR_SYNC) && i_clk_en)
      |=> !o_sync_pulse)
    else $error("One-shot sync honoured a second event.");

endmodule // adc_control_register_bank

// ==== verification/adc_host_model.sv ====
// Host controller model that drives the register port of the converter control bank.
`timescale 1ns/1ps
module adc_host_model
  import adc_ctrl_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic [7:0]  i_rd_data,
  input  wire logic        i_rd_valid,
  output logic             o_wr_en,
  output logic             o_rd_en,
  output logic      [12:0] o_addr,
  output logic      [7:0]  o_wr_data
);
  initial begin
    o_wr_en   = 1'b0;
    o_rd_en   = 1'b0;
    o_addr    = 13'h1FFF;
    o_wr_data = 8'hFF;
  end

  task automatic put(input logic w, input logic r, input logic [12:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_wr_en   = w;
    o_rd_en   = r;
    o_addr    = a;
    o_wr_data = d;
  endtask

  // A released bus shows the inverse of its last value, so stale data never looks like a fresh request.
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    put(1'b1, 1'b0, a, d);
    put(1'b0, 1'b0, ~a, ~d);
  endtask

  // Read data is taken one edge after the request, as the port answers.
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    put(1'b0, 1'b1, a, 8'h00);
    put(1'b0, 1'b0, ~a, 8'hFF);
    d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hXX;
  endtask

  task automatic commit_downgrade();
    wr(ADDR_TRANSFER, 8'h01);
  endtask
endmodule // adc_host_model

// ==== verification/adc_control_register_bank_tb_top.sv ====
// Self-checking testbench of the converter control register bank.
`timescale 1ns/1ps
module adc_control_register_bank_tb_top;
  import adc_ctrl_pkg::*;
  logic        i_core_clk, i_resetn, i_clk_en, i_external_powerdown_pin, i_sync_event;
  logic        i_wr_en, i_rd_en, o_rd_valid, o_datapath_clk_en, o_datapath_reset, o_output_en, o_chop_en;
  logic [12:0] i_addr;
  logic [7:0]  i_wr_data, o_rd_data;
  logic [3:0]  o_chan_powerdown, o_chan_output_reset;
  logic [1:0]  o_clkch_powerdown, o_clkch_output_reset, o_serial_word_size, o_resolution_code;
  logic [2:0]  o_ser_lane_mode, o_max_rate_code;
  logic        o_ser_lsb_first, o_ser_pll_low_rate, o_ser_double_frame, o_override_en;
  logic        o_sdio_pulldown_dis, o_common_mode_voltage_pd, o_sync_en, o_sync_pulse;
  int          n_errors = 0;
  int          n_compared = 0;

  wire logic [2:0] pwr = {o_datapath_clk_en, o_datapath_reset, o_output_en};
  wire logic [7:0] dg  = {1'b0, o_override_en, o_resolution_code, 1'b0, o_max_rate_code};

  adc_control_register_bank u_dut (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_external_powerdown_pin(i_external_powerdown_pin),
    .i_sync_event(i_sync_event), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_datapath_clk_en(o_datapath_clk_en), .o_datapath_reset(o_datapath_reset), .o_output_en(o_output_en),
    .o_chop_en(o_chop_en), .o_chan_powerdown(o_chan_powerdown), .o_chan_output_reset(o_chan_output_reset),
    .o_clkch_powerdown(o_clkch_powerdown), .o_clkch_output_reset(o_clkch_output_reset),
    .o_ser_lsb_first(o_ser_lsb_first), .o_ser_lane_mode(o_ser_lane_mode), .o_ser_pll_low_rate(o_ser_pll_low_rate),
    .o_ser_double_frame(o_ser_double_frame), .o_serial_word_size(o_serial_word_size),
    .o_override_en(o_override_en), .o_resolution_code(o_resolution_code), .o_max_rate_code(o_max_rate_code),
    .o_sdio_pulldown_dis(o_sdio_pulldown_dis), .o_common_mode_voltage_pd(o_common_mode_voltage_pd),
    .o_sync_en(o_sync_en), .o_sync_pulse(o_sync_pulse));

  adc_host_model u_host (
    .i_core_clk(i_core_clk), .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid),
    .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wr_data(i_wr_data));

  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rchk(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk($sformatf("register %h", a), d, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  task automatic t_reset();
    rchk(ADDR_CHANNEL_INDEX, 8'h3F);
    rchk(ADDR_SER_FORMAT, 8'h30);
    rchk(ADDR_CH_PWR_RST, 8'h00);
    rchk(ADDR_DOWNGRADE, 8'h00);
    rchk(13'h0AB, 8'h00);
    chk("lane mode", {5'h00, o_ser_lane_mode}, 8'h03);
    chk("power", {5'h00, pwr}, 8'h05);
  endtask

  task automatic t_masks();
    logic [12:0] a [4] = '{ADDR_OFFSET_CHOP, ADDR_IO_PULLDOWN, ADDR_CM_POWER, ADDR_SYNC};
    logic [7:0]  m [4] = '{8'h04, 8'h01, 8'h08, 8'h03};
    for (int i = 0; i < 4; i++) begin
      rchk(a[i], 8'h00);
      u_host.wr(a[i], 8'hFF);
      rchk(a[i], m[i]);
    end
    chk("chop", {7'h00, o_chop_en}, 8'h01);
    chk("pull-down", {7'h00, o_sdio_pulldown_dis}, 8'h01);
    chk("common mode", {7'h00, o_common_mode_voltage_pd}, 8'h01);
    u_host.wr(ADDR_OFFSET_CHOP, 8'h00);
    idle(1);
    chk("chop off", {7'h00, o_chop_en}, 8'h00);
  endtask

  task automatic t_serfmt();
    logic [7:0] v [2] = '{8'hA6, 8'h34};
    for (int i = 0; i < 2; i++) begin
      u_host.wr(ADDR_SER_FORMAT, v[i]);
      idle(1);
      chk("format", {o_ser_lsb_first, o_ser_lane_mode, o_ser_pll_low_rate, o_ser_double_frame,
                     o_serial_word_size}, v[i]);
    end
  endtask

  task automatic t_power();
    logic [2:0] e [4] = '{3'b101, 3'b010, 3'b000, 3'b110};
    for (int f = 0; f < 4; f++) begin
      u_host.wr(ADDR_POWER_MODE, 8'(f));
      idle(1);
      chk("power mode", {5'h00, pwr}, {5'h00, e[f]});
    end
    u_host.wr(ADDR_POWER_MODE, 8'hFF);
    rchk(ADDR_POWER_MODE, 8'h23);
    u_host.wr(ADDR_POWER_MODE, 8'h20);
    i_external_powerdown_pin = 1'b1;
    idle(2);
    chk("pin standby", {5'h00, pwr}, 8'h00);
    u_host.wr(ADDR_POWER_MODE, 8'h00);
    idle(1);
    chk("pin full", {5'h00, pwr}, 8'h02);
    i_external_powerdown_pin = 1'b0;
    idle(2);
    chk("pin off", {5'h00, pwr}, 8'h05);
  endtask

  task automatic t_channel();
    u_host.wr(ADDR_CHANNEL_INDEX, 8'h05);
    u_host.wr(ADDR_CH_PWR_RST, 8'h02);
    idle(1);
    chk("data ch", {o_chan_output_reset, o_chan_powerdown}, 8'h50);
    chk("clock ch", {4'h0, o_clkch_output_reset, o_clkch_powerdown}, 8'h00);
    u_host.wr(ADDR_CHANNEL_INDEX, 8'h20);
    u_host.wr(ADDR_CH_PWR_RST, 8'h01);
    idle(1);
    chk("data kept", {o_chan_output_reset, o_chan_powerdown}, 8'h50);
    chk("clock ch", {4'h0, o_clkch_output_reset, o_clkch_powerdown}, 8'h02);
    rchk(ADDR_CH_PWR_RST, 8'h01);
  endtask

  task automatic t_downgrade();
    u_host.wr(ADDR_DOWNGRADE, 8'hFF);
    rchk(ADDR_DOWNGRADE, 8'h77);
    u_host.wr(ADDR_DOWNGRADE, 8'h56);
    u_host.wr(ADDR_TRANSFER, 8'h00);
    idle(1);
    chk("held", dg, 8'h00);
    u_host.commit_downgrade();
    idle(1);
    chk("applied", dg, 8'h56);
    u_host.wr(ADDR_DOWNGRADE, 8'h00);
    idle(1);
    chk("pending only", dg, 8'h56);
    rchk(ADDR_TRANSFER, 8'h00);
  endtask

  // Counts pulses over three cycles, wide enough for either output latency.
  task automatic sync_ev(output int n);
    n = 0;
    i_sync_event = 1'b1;
    repeat (3) begin
      @(negedge i_core_clk);
      i_sync_event = 1'b0;
      n += int'(o_sync_pulse === 1'b1);
    end
  endtask

  task automatic t_sync();
    logic [7:0] cfg [3] = '{8'h01, 8'h03, 8'h00};
    logic [7:0] ex [6] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    int n;
    for (int i = 0; i < 3; i++) begin
      u_host.wr(ADDR_SYNC, cfg[i]);
      for (int k = 0; k < 2; k++) begin
        sync_ev(n);
        chk("sync pulses", 8'(n), ex[2 * i + k]);
      end
      chk("sync enable", {7'h00, o_sync_en}, {7'h00, cfg[i][SYNC_EN_BIT]});
    end
  endtask

  task automatic close_out();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles, so four thousand means a hang.
  initial begin
    #(4000 * 40);
    n_errors++;
    close_out();
  end

  initial begin
    i_resetn = 1'b0;
    i_clk_en = 1'b1;
    i_external_powerdown_pin = 1'b0;
    i_sync_event = 1'b0;
    repeat (12) @(negedge i_core_clk);
    i_resetn = 1'b1;
    t_reset();
    t_masks();
    t_serfmt();
    t_power();
    t_channel();
    t_downgrade();
    t_sync();
    close_out();
  end
endmodule // adc_control_register_bank_tb_top
